/* File: hdl/sspc_regs.vh */
// Field positions, reset values and codes of the synthesizer serial port
`ifndef SSPC_REGS_VH
`define SSPC_REGS_VH

`define SSPC_WORD_BITS      20
// Select field, serial bits 1 and 2 sit at word index 0 and 1
`define SSPC_SEL_REF        2'h0
`define SSPC_SEL_AB         2'h2
`define SSPC_SEL_MODE       2'h1
`define SSPC_SEL_NONE       2'h3
// Reference count, serial bits 3..17
`define SSPC_REF_LSB        2
`define SSPC_REF_MSB        16
// Swallow count bits 3..9, main count bits 10..20
`define SSPC_SWL_LSB        2
`define SSPC_SWL_MSB        8
`define SSPC_MAIN_LSB       9
`define SSPC_MAIN_MSB       19
// Mode word positions
`define SSPC_M0_POS         2
`define SSPC_M2_LSB         4
`define SSPC_M2_MSB         10
`define SSPC_M13_LSB        15
`define SSPC_M13_MSB        17
// Reset values
`define SSPC_REF_RST        15'h0003
`define SSPC_SWL_RST        7'h00
`define SSPC_MAIN_RST       11'h003
`define SSPC_MODE_RST       16'h0000
// Mode bit indices
`define SSPC_MB_ENABLE      0
`define SSPC_MB_PRESC       2
`define SSPC_MB_LD0         7
`define SSPC_MB_LD1         8
`define SSPC_MB_LD2         13
// Prescaler moduli
`define SSPC_PRESC_LO       7'h20
`define SSPC_PRESC_HI       7'h40
// Power state codes
`define SSPC_ST_OFF         3'h0
`define SSPC_ST_SAVE        3'h1
`define SSPC_ST_RX          3'h2
`define SSPC_ST_TX          3'h3
`define SSPC_ST_IDLE        3'h4

`endif

/* File: hdl/sspc_pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sspc_pin_sync (
    input  wire clock,
    input  wire reset_n,
    input  wire pinIn,
    output reg  level,
    output reg  rise
);
    reg [2:0] stage_q;

    // Capture pin, change accepted once stages two and three agree
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= 3'h0;
            level   <= 1'b0;
            rise    <= 1'b0;
        end else begin
            stage_q <= {stage_q[1:0], pinIn};
            rise    <= 1'b0;
            if (stage_q[1] == stage_q[2] && stage_q[2] != level) begin
                level <= stage_q[2];
                rise  <= stage_q[2];
            end
        end
    end
endmodule // sspc_pin_sync
`default_nettype wire

/* File: hdl/sspc_divider.v */
// Programmable divide-by-N counter on a sampled input clock
`timescale 1ns/1ps
`default_nettype none
module sspc_divider (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        enable,
    input  wire        tick,
    input  wire [17:0] divisor,
    output reg         pulse,
    output reg         wave
);
    reg [17:0] count_q;

    // Count input edges, pulse every divisor edges
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 18'h0_0000;
            pulse   <= 1'b0;
            wave    <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (!enable) begin
                count_q <= 18'h0_0000;
                wave    <= 1'b0;
            end else if (tick) begin
                if (count_q + 18'h0_0001 >= divisor) begin
                    count_q <= 18'h0_0000;
                    pulse   <= 1'b1;
                    wave    <= 1'b1;
                end else begin
                    count_q <= count_q + 18'h0_0001;
                    if (count_q + 18'h0_0001 >= {1'b0, divisor[17:1]})
                        wave <= 1'b0;
                end
            end
        end
    end
endmodule // sspc_divider
`default_nettype wire

/* File: hdl/sspc_serial_power.v */
// Serial programming port and power-enable logic of the synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.vh"
module sspc_serial_power (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        serialClock,
    input  wire        serialData,
    input  wire        latchStrobe,
    input  wire        powerEnablePinFirst,
    input  wire        powerEnablePinSecond,
    input  wire        refInput,
    input  wire        oscInput,
    input  wire        lockDetect,
    output reg         lockOutputPin,
    output wire        loBufferEnable,
    output wire        synthEnable,
    output wire        receiveActive,
    output wire        transmitActive,
    output wire        loopSaveMode,
    output reg  [2:0]  powerState,
    output reg  [14:0] refCount,
    output reg  [6:0]  swallowCount,
    output reg  [10:0] mainCount,
    output reg  [15:0] modeWord,
    output wire        refPhasePulse,
    output wire        oscPhasePulse
);
    // Synchronised pins
    wire sclkLevel;
    wire sclkRise;
    wire sdatLevel;
    wire latchLevel;
    wire latchRise;
    wire pe1Level;
    wire pe2Level;
    wire refRise;
    wire oscRise;
    wire refWave;
    wire oscWave;

    // Shift register and readback
    reg  [19:0] shift_q;
    reg  [19:0] lastWord_q;
    reg         latchPrev_q;
    reg         latchArmed_q;

    // Oscillator divider state
    reg  [6:0]  prescCount_q;
    reg         prescPhase_q;
    reg  [10:0] mainCnt_q;
    reg  [6:0]  swlCnt_q;
    reg  [1:0]  pinPair;
    reg  [2:0]  stateNext;

    wire        synthBit;
    wire        loopOn;
    wire        prescPulse;
    wire [6:0]  prescMod;

    // Decode select field into a target code
    function [1:0] sspcSelect;
        input [19:0] word;
        begin
            sspcSelect = word[1:0];
        end
    endfunction

    // Fold the shifted word into the mode layout
    function [15:0] sspcModeOf;
        input [19:0] word;
        begin
            sspcModeOf = 16'h0000;
            sspcModeOf[0] = word[`SSPC_M0_POS];
            sspcModeOf[8:2] = word[`SSPC_M2_MSB:`SSPC_M2_LSB];
            sspcModeOf[15:13] = word[`SSPC_M13_MSB:`SSPC_M13_LSB];
        end
    endfunction

    // Pin synchronisers, one per outside input except lockDetect
    sspc_pin_sync uSyncSclk (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (serialClock),
        .level   (sclkLevel),
        .rise    (sclkRise)
    );
    sspc_pin_sync uSyncData (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (serialData),
        .level   (sdatLevel),
        .rise    ()
    );
    sspc_pin_sync uSyncLatch (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (latchStrobe),
        .level   (latchLevel),
        .rise    (latchRise)
    );
    sspc_pin_sync uSyncPe1 (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (powerEnablePinFirst),
        .level   (pe1Level),
        .rise    ()
    );
    sspc_pin_sync uSyncPe2 (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (powerEnablePinSecond),
        .level   (pe2Level),
        .rise    ()
    );
    sspc_pin_sync uSyncRef (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (refInput),
        .level   (),
        .rise    (refRise)
    );
    sspc_pin_sync uSyncOsc (
        .clock   (clock),
        .reset_n (reset_n),
        .pinIn   (oscInput),
        .level   (),
        .rise    (oscRise)
    );

    // Arm word transfer only after the strobe is seen falling.
    // The synchroniser leaves reset low while an idle strobe sits
    // high, so the first rise after reset is no frame end; without
    // this, that false rise would load an all-zero word.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latchPrev_q  <= 1'b0;
            latchArmed_q <= 1'b0;
        end else begin
            latchPrev_q <= latchLevel;
            if (latchPrev_q && !latchLevel) begin
                latchArmed_q <= 1'b1;
            end else if (latchRise) begin
                latchArmed_q <= 1'b0;
            end
        end
    end

    // Shift register, MSB first, only while strobe low.
    // Clock and data pass equal synchroniser depth, so data seen
    // at the clock rise is the level the host set before it.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 20'h0_0000;
        end else if (sclkRise && !latchLevel) begin
            shift_q <= {shift_q[18:0], sdatLevel};
        end
    end

    // Word transfer on strobe rise; registers never cleared by power
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            refCount     <= `SSPC_REF_RST;
            swallowCount <= `SSPC_SWL_RST;
            mainCount    <= `SSPC_MAIN_RST;
            modeWord     <= `SSPC_MODE_RST;
            lastWord_q   <= 20'h0_0000;
        end else if (latchRise && latchArmed_q) begin
            lastWord_q <= shift_q;
            case (sspcSelect(shift_q))
                `SSPC_SEL_REF: begin
                    refCount <= shift_q[`SSPC_REF_MSB:`SSPC_REF_LSB];
                end
                `SSPC_SEL_AB: begin
                    swallowCount <= shift_q[`SSPC_SWL_MSB:`SSPC_SWL_LSB];
                    mainCount    <= shift_q[`SSPC_MAIN_MSB:`SSPC_MAIN_LSB];
                end
                `SSPC_SEL_MODE: begin
                    modeWord <= sspcModeOf(shift_q);
                end
                default: begin
                    lastWord_q <= lastWord_q;
                end
            endcase
        end
    end

    // Power decisions
    assign synthBit       = modeWord[`SSPC_MB_ENABLE];
    assign synthEnable    = synthBit & (pe1Level | pe2Level);
    assign loBufferEnable = pe1Level | pe2Level;
    assign receiveActive  = (powerState == `SSPC_ST_RX);
    assign transmitActive = (powerState == `SSPC_ST_TX);
    assign loopSaveMode   = (powerState == `SSPC_ST_SAVE);
    assign loopOn         = synthEnable &&
                            (powerState != `SSPC_ST_IDLE);

    // Truth table of pin pair with enable bit
    always @* begin
        pinPair = {pe1Level, pe2Level};
        if (!synthBit) begin
            stateNext = `SSPC_ST_OFF;
        end else begin
            case (pinPair)
                2'h3: stateNext = `SSPC_ST_RX;
                2'h2: stateNext = `SSPC_ST_TX;
                2'h0: stateNext = `SSPC_ST_SAVE;
                2'h1: stateNext = `SSPC_ST_IDLE;
                default: stateNext = `SSPC_ST_OFF;
            endcase
        end
    end

    // Registered power state
    // One cycle behind the synchronised pins, free of glitches
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            powerState <= `SSPC_ST_OFF;
        end else begin
            powerState <= stateNext;
        end
    end

    // Reference divider feeding the phase detector
    // Held cleared while the loop is off, so it restarts in phase
    // when the enable bit or a power pin returns
    sspc_divider uRefDiv (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (loopOn),
        .tick    (refRise),
        .divisor ({3'h0, refCount}),
        .pulse   (refPhasePulse),
        .wave    (refWave)
    );

    // Prescaler modulus from mode bit 2
    assign prescMod = modeWord[`SSPC_MB_PRESC] ? `SSPC_PRESC_HI
                                               : `SSPC_PRESC_LO;

    // Dual-modulus prescaler: P+1 while swallow remains, else P
    // The count runs 0..P while swallowing and 0..P-1 otherwise.
    // Limitation: a swallow count above the main count is only
    // partly honoured, as in any dual-modulus divider.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prescCount_q <= 7'h00;
        end else if (!loopOn) begin
            prescCount_q <= 7'h00;
        end else if (oscRise) begin
            if (prescPulse)
                prescCount_q <= 7'h00;
            else
                prescCount_q <= prescCount_q + 7'h01;
        end
    end
    assign prescPulse = oscRise &&
        (prescCount_q == ((swlCnt_q != 7'h00) ? prescMod : prescMod - 7'h01));

    // Main and swallow counters give P*B+A overall
    // Swallow reloads at each output pulse and while the loop is
    // off, so a new swallow count applies from the next cycle
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mainCnt_q    <= 11'h000;
            swlCnt_q     <= 7'h00;
            prescPhase_q <= 1'b0;
        end else if (!loopOn) begin
            mainCnt_q    <= 11'h000;
            swlCnt_q     <= swallowCount;
            prescPhase_q <= 1'b0;
        end else begin
            prescPhase_q <= 1'b0;
            if (prescPulse) begin
                if (mainCnt_q + 11'h001 >= mainCount) begin
                    mainCnt_q    <= 11'h000;
                    swlCnt_q     <= swallowCount;
                    prescPhase_q <= 1'b1;
                end else begin
                    mainCnt_q <= mainCnt_q + 11'h001;
                    if (swlCnt_q != 7'h00)
                        swlCnt_q <= swlCnt_q - 7'h01;
                end
            end
        end
    end
    assign oscPhasePulse = prescPhase_q;
    assign oscWave       = (mainCnt_q < {1'b0, mainCount[10:1]});

    // Lock pin multiplexer
    // Registered so the pin never glitches on a mode change;
    // readback shows the top bit of the last latched word whose select is not SSPC_SEL_NONE
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lockOutputPin <= 1'b0;
        end else begin
            case ({modeWord[`SSPC_MB_LD2], modeWord[`SSPC_MB_LD1]})
                2'h0: lockOutputPin <= lockDetect;
                2'h1: lockOutputPin <= 1'b0;
                2'h2: lockOutputPin <= lastWord_q[19];
                default: begin
                    if (modeWord[`SSPC_MB_LD0])
                        lockOutputPin <= oscWave;
                    else
                        lockOutputPin <= refWave;
                end
            endcase
        end
    end
endmodule // sspc_serial_power
`default_nettype wire

/* File: verif/sspc_serial_power_monitor.sv */
// Concurrent checks on the serial port and power pins
`timescale 1ns/1ps
`default_nettype none
`include "sspc_regs.vh"
module sspc_monitor (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        latchStrobe,
    input wire logic        powerEnablePinFirst,
    input wire logic        powerEnablePinSecond,
    input wire logic        lockDetect,
    input wire logic        lockOutputPin,
    input wire logic        loBufferEnable,
    input wire logic        synthEnable,
    input wire logic        receiveActive,
    input wire logic        transmitActive,
    input wire logic        loopSaveMode,
    input wire logic [2:0]  powerState,
    input wire logic [14:0] refCount,
    input wire logic [6:0]  swallowCount,
    input wire logic [10:0] mainCount,
    input wire logic [15:0] modeWord
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Power decode against enable bit and pins
    synth_and_a: assert property (
        synthEnable == (modeWord[0] && loBufferEnable))
        else $error("synth enable wrong");
    lo_on_a: assert property (
        (powerEnablePinFirst [*6]) |-> loBufferEnable)
        else $error("buffer enable late");
    rx_decode_a: assert property (
        receiveActive == (powerState == `SSPC_ST_RX))
        else $error("receive decode wrong");
    tx_decode_a: assert property (
        transmitActive == (powerState == `SSPC_ST_TX))
        else $error("transmit decode wrong");
    save_decode_a: assert property (
        loopSaveMode == (powerState == `SSPC_ST_SAVE))
        else $error("save decode wrong");
    disabled_off_a: assert property (
        !modeWord[0] && !$past(modeWord[0]) |-> powerState == `SSPC_ST_OFF)
        else $error("loop active while disabled");
    // Registers move only after a strobe rise
    regs_hold_a: assert property (
        (!latchStrobe [*8]) |->
            $stable({refCount, swallowCount, mainCount, modeWord}))
        else $error("register changed while shifting");
    // Lock pin selection
    lock_detect_a: assert property (
        !modeWord[13] && !modeWord[8] |=> lockOutputPin == $past(lockDetect))
        else $error("lock pin not lock detect");
    lock_ground_a: assert property (
        !modeWord[13] && modeWord[8] |=> !lockOutputPin)
        else $error("lock pin not grounded");
endmodule // sspc_monitor
`default_nettype wire

/* File: verif/sspc_host_model.sv */
// Host controller model driving the three-wire programming port
`timescale 1ns/1ps
`default_nettype none
module sspc_host_model (
    output logic serialClock,
    output logic serialData,
    output logic latchStrobe
);
    // Idle port: clock still, strobe high
    initial begin
        serialClock = 0;
        serialData  = 0;
        latchStrobe = 1;
    end
    // One bit per 48 ns, data set a half period before the rise
    task automatic bitOut(input logic b);
        serialData = b;
        #24 serialClock = 1;
        #24 serialClock = 0;
    endtask
    // Strobe rises after the last bit, data line then set to the inverse of that bit
    task automatic endFrame(input logic d);
        #24 latchStrobe = 1;
        serialData = d;
        #200;
    endtask
    // Framed word, most significant bit first
    task automatic send(input logic [19:0] w);
        latchStrobe = 0;
        for (int i = 19; i >= 0; i--) bitOut(w[i]);
        endFrame(~w[0]);
    endtask
    task automatic sendLong(input logic [23:0] w);
        latchStrobe = 0;
        for (int i = 23; i >= 0; i--) bitOut(w[i]);
        endFrame(~w[0]);
    endtask
    // Clock pulses with strobe high, then a bare strobe pulse
    task automatic strayBits(input logic [3:0] w);
        for (int i = 3; i >= 0; i--) bitOut(w[i]);
        latchStrobe = 0;
        #48 latchStrobe = 1;
        #200;
    endtask
endmodule // sspc_host_model
`default_nettype wire

/* File: verif/sspc_testbench.sv */
// Self-checking bench of the synthesizer serial port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
module testbench;
    logic        clock = 0, reset_n = 0, lockDetect = 0, lockQ = 0;
    logic        powerEnablePinFirst = 0, powerEnablePinSecond = 0;
    logic        refInput = 0, oscInput = 0;
    wire         serialClock, serialData, latchStrobe, lockOutputPin;
    wire         loBufferEnable, synthEnable, receiveActive;
    wire         transmitActive, loopSaveMode, refPhasePulse, oscPhasePulse;
    wire  [2:0]  powerState;
    wire  [14:0] refCount;
    wire  [6:0]  swallowCount;
    wire  [10:0] mainCount;
    wire  [15:0] modeWord;
    int          n_fail = 0, checked = 0, cycles = 0;
    int          refN = 0, oscN = 0, lockN = 0;
    logic [15:0] lm [5] = '{16'h0001, 16'h0101, 16'h2001, 16'h2101, 16'h2181};

    sspc_serial_power uut (
        .clock, .reset_n, .serialClock, .serialData, .latchStrobe,
        .powerEnablePinFirst, .powerEnablePinSecond, .refInput, .oscInput,
        .lockDetect, .lockOutputPin, .loBufferEnable, .synthEnable,
        .receiveActive, .transmitActive, .loopSaveMode, .powerState,
        .refCount, .swallowCount, .mainCount, .modeWord, .refPhasePulse,
        .oscPhasePulse
    );
    sspc_host_model host (.serialClock, .serialData, .latchStrobe);

    // Clock
    always #2 clock = ~clock;
    // Cycle ceiling and pulse counters
    always @(posedge clock) begin
        cycles <= cycles + 1;
        refN <= refN + refPhasePulse;
        oscN <= oscN + oscPhasePulse;
        lockN <= lockN + (lockOutputPin & ~lockQ);
        lockQ <= lockOutputPin;
        if (cycles == 50000) begin
            n_fail++;
            final_report();
        end
    end

    function automatic logic [19:0] modeW(input logic [15:0] m);
        return {2'b11, m[15:13], 4'h0, m[8:2], 1'b0, m[0], 2'b01};
    endfunction
    task automatic setPins(input logic [1:0] p);
        @(posedge clock);
        #1 {powerEnablePinFirst, powerEnablePinSecond} = p;
        repeat (10) @(posedge clock);
        #1;
    endtask
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (4) @(posedge clock);
            #1 {refInput, oscInput} = 2'b11;
            repeat (4) @(posedge clock);
            #1 {refInput, oscInput} = 2'b00;
        end
    endtask

    task automatic t_reset;
        repeat (2) @(posedge clock);
        `CHECK({refCount, mainCount, swallowCount, modeWord, powerState}, {15'h0003, 11'h003, 7'h00, 16'h0000, 3'h0})
        repeat (12) @(posedge clock);
        #1;
        `CHECK({refCount, mainCount, modeWord}, {15'h0003, 11'h003, 16'h0000})
        $display("reset test done");
    endtask
    task automatic t_words;
        host.send({3'h7, 15'h7fff, 2'h0});
        `CHECK(refCount, 15'h7fff)
        host.send({3'h0, 15'h0003, 2'h0});
        `CHECK(refCount, 15'h0003)
        host.send({11'h7ff, 7'h7f, 2'h2});
        `CHECK({mainCount, swallowCount}, 18'h3_ffff)
        host.send({11'h003, 7'h00, 2'h2});
        `CHECK({mainCount, swallowCount}, 18'h0_0180)
        host.send(modeW(16'hfffd));
        `CHECK(modeWord, 16'he1fd)
        host.send(20'h5_a5a7);
        `CHECK({refCount, modeWord}, {15'h0003, 16'he1fd})
        host.sendLong({4'h9, 11'h005, 7'h0c, 2'h2});
        `CHECK({mainCount, swallowCount}, {11'h005, 7'h0c})
        host.strayBits(4'h9);
        `CHECK({mainCount, swallowCount, modeWord}, {11'h005, 7'h0c, 16'he1fd})
        $display("word test done");
    endtask
    task automatic t_power;
        host.send(modeW(16'h0001));
        for (int e = 1; e >= 0; e--) begin
            for (int p = 0; p < 4; p++) begin
                setPins(p[1:0]);
                `CHECK({receiveActive, transmitActive, loopSaveMode}, e ? {p == 3, p == 2, p == 0} : 3'h0)
                `CHECK(loBufferEnable, p != 0)
                `CHECK(synthEnable, e && p != 0)
            end
            host.send(modeW(16'h0000));
        end
        `CHECK({refCount, mainCount}, {15'h0003, 11'h005})
        $display("power test done");
    endtask
    task automatic t_divider;
        int r, o, e;
        setPins(2'h3);
        host.send({11'h003, 7'h01, 2'h2});
        for (int m = 0; m < 2; m++) begin
            host.send(modeW({13'h0, m[0], 2'h1}));
            e = 576 / (m ? 193 : 97);
            r = refN;
            o = oscN;
            toggle(576);
            `CHECK((refN - r) inside {[191:193]}, 1'b1)
            `CHECK((oscN - o - e) inside {0, 1}, 1'b1)
        end
        $display("divider test done");
    endtask
    task automatic t_lock;
        int l;
        for (int k = 0; k < 5; k++) begin
            host.send(modeW(lm[k]));
            @(posedge clock);
            #1 lockDetect = 1;
            l = lockN;
            toggle(300);
            `CHECK(k < 3 ? lockOutputPin : lockN > l, k != 1)
            lockDetect = 0;
        end
        $display("lock test done");
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clock);
        #1 reset_n = 1;
        t_reset();
        t_words();
        t_power();
        t_divider();
        t_lock();
        final_report();
    end
endmodule // testbench

bind sspc_serial_power sspc_monitor mon (
    .clock, .reset_n, .latchStrobe, .powerEnablePinFirst,
    .powerEnablePinSecond, .lockDetect, .lockOutputPin, .loBufferEnable,
    .synthEnable, .receiveActive, .transmitActive, .loopSaveMode,
    .powerState, .refCount, .swallowCount, .mainCount, .modeWord
);
`default_nettype wire
